/* design/dep_regs.svh */
// register offsets, field positions and reset values of the
// drawing engine parameter bank; definitions only
`ifndef DEP_REGS_SVH
`define DEP_REGS_SVH
`define DEP_AXSTEP    16'h8ae8
`define DEP_DIASTEP   16'h8ee8
`define DEP_ERRTERM   16'h92e8
`define DEP_MAJOR     16'h96e8
`define DEP_CMDSTAT   16'h9ae8
`define DEP_STROKE    16'h9ee8
`define DEP_BGCOL     16'ha2e8
`define DEP_FGCOL     16'ha6e8
`define DEP_WMASK     16'haae8
`define DEP_RMASK     16'haee8
`define DEP_CMPCOL    16'hb2e8
`define DEP_BGMIX     16'hb6e8
`define DEP_FGMIX     16'hbae8
`define DEP_MODE      16'hc2e8
`define DEP_MODE_WIDE 0
`define DEP_MODE_HALF 4
`define DEP_MODE_POL  7
`define DEP_MODE_CMP  8
`define DEP_CMD_SWAP  12
`define DEP_QSLOTS    4'h8
`define DEP_RST32     32'h0000_0000
`endif

/* design/dep_pkg.sv */
// types of the drawing engine parameter bank
// assumes nothing beyond a SystemVerilog compiler
package dep_pkg;
   typedef enum logic [1:0] {
      DEP_IDLE = 2'b00,
      DEP_RUN  = 2'b01,
      DEP_VEC  = 2'b10
   } dep_state_t;
   typedef enum logic [2:0] {
      DEP_OP_NONE    = 3'b000,
      DEP_OP_LINE    = 3'b001,
      DEP_OP_FILL    = 3'b010,
      DEP_OP_VECTOR  = 3'b011,
      DEP_OP_COPY    = 3'b110,
      DEP_OP_PATTERN = 3'b111
   } dep_op_t;
   typedef struct packed {
      dep_op_t     op;
      logic        memory_direction;
      logic        multi_pixel_select;
      logic        skip_final_pixel;
      logic        angle_style_select;
      logic        draw_enable;
      logic [2:0]  heading_code;
      logic        host_data_wait;
      logic        wide_port;
      logic        low_byte_first;
      logic [12:0] pixel_count;
      logic [11:0] dest_x;
      logic [13:0] axial_step;
      logic [13:0] diagonal_step;
      logic [13:0] line_error_term;
   } dep_issue_t;
   typedef struct packed {
      logic [31:0] background_color;
      logic [31:0] foreground_color;
      logic [31:0] plane_write_mask;
      logic [31:0] plane_read_mask;
      logic [31:0] compare_color;
      logic [3:0]  bg_mix_fn;
      logic [1:0]  bg_new_colour_source;
      logic [3:0]  fg_mix_fn;
      logic [1:0]  fg_new_colour_source;
      logic        compare_enable;
      logic        compare_polarity;
   } dep_pixel_cfg_t;
   typedef struct packed {
      logic             waitreq;
      logic [31:0]      rdata;
      logic [15:0]      axial_step;
      logic [15:0]      diag_step;
      logic [15:0]      error_term;
      logic [15:0]      major_count;
      logic [15:0]      bg_mix;
      logic [15:0]      fg_mix;
      logic [31:0]      bg_color;
      logic [31:0]      fg_color;
      logic [31:0]      wmask;
      logic [31:0]      rmask;
      logic [31:0]      cmp_color;
      logic [8:0]       mode;
      logic             last_swap;
      logic [7:0][16:0] queue;
      logic [2:0]       head;
      logic [2:0]       tail;
      logic [3:0]       count;
      dep_state_t       st;
      logic [7:0]       pend_vec;
      dep_issue_t       issue;
      logic             issue_valid;
      logic             busy;
   } dep_state_regs_t;
endpackage

/* design/dep_param_regs.sv */
// parameter, command and status bank of the 2-D drawing engine
// assumes an Avalon-MM master on clk and an engine that pulses
// engine_done once per issued operation
`timescale 1ns/1ps
`default_nettype none
`include "dep_regs.svh"

// What this block does
// - low 12 bits of shared register are destination X for copy, pattern
// - major axis count holds pixel count minus one
// - status low byte shows queue occupancy as thermometer code
// - status bit 8 shows pixel port read data waiting
// - status bit 9 busy while executing, bit 10 when queue empty
// - command bit 0 memory direction, bit 1 multi pixel mode
// - command bit 2 omits final pixel of line; short stroke vectors always draw it
// - bit 3 axial or radial heading, bit 4 draw or move only
// - command bits 7 to 5 give heading code
// - command bit 8 makes engine wait for host pixel data
// - bit 9 selects port width, bit 12 byte order
// - command type decode: nop, line, fill, copy, pattern; others reserved
// - line uses step constants or encoded angle per bit 3
// - fill draws rows of major count plus one pixels, minor-count rows
// - copy moves rectangle, pattern repeats 8x8 tile; source X aligned
// - short stroke word holds two vectors drawn in byte order
// - wide pixel mode: 16-bit halves of colour registers, flag toggles
// - write mask gates planes, read mask selects source planes
// - compare enable and polarity decide suppressed pixel updates
// - mix low nibble picks one of sixteen logic combinations
// - mix source field picks background, foreground, host or memory
module dep_param_regs (
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic                 ce,
   input  wire logic [15:0]          avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest,
   input  wire logic                 read_word_ready,
   input  wire logic                 engine_done,
   output var dep_pkg::dep_issue_t   issue,
   output logic                      issue_valid,
   output var dep_pkg::dep_pixel_cfg_t pixel_cfg
);
   localparam int SW = $bits(dep_pkg::dep_state_regs_t);
   localparam dep_pkg::dep_state_regs_t RST_ST =
      dep_pkg::dep_state_regs_t'({1'b1, {(SW - 1){1'b0}}});

   dep_pkg::dep_state_regs_t r;
   dep_pkg::dep_state_regs_t next_r;
   logic        stall;
   logic        acc;
   logic        push;
   logic        pop;
   logic        col_hit;
   logic [16:0] entry;
   logic [16:0] head_e;
   logic [8:0]  therm9;
   logic [7:0]  therm;

   function automatic logic [15:0] m16(input logic [15:0] old,
                                       input logic [15:0] wd,
                                       input logic [1:0]  be);
      m16 = {be[1] ? wd[15:8] : old[15:8],
             be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // wide mode moves one 16-bit half per access
   function automatic logic [31:0] wr32(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be,
                                        input logic        wide,
                                        input logic        half);
      if (!wide) begin
         wr32 = {m16(old[31:16], wd[31:16], be[3:2]),
                 m16(old[15:0], wd[15:0], be[1:0])};
      end else if (half) begin
         wr32 = {m16(old[31:16], wd[15:0], be[1:0]), old[15:0]};
      end else begin
         wr32 = {old[31:16], m16(old[15:0], wd[15:0], be[1:0])};
      end
   endfunction

   function automatic logic [31:0] rd32(input logic [31:0] v,
                                        input logic        wide,
                                        input logic        half);
      if (!wide) begin
         rd32 = v;
      end else begin
         rd32 = {16'h0000, half ? v[31:16] : v[15:0]};
      end
   endfunction

   function automatic dep_pkg::dep_issue_t vec_issue(input logic [7:0] b);
      dep_pkg::dep_issue_t i;
      i = '0;
      i.op = dep_pkg::DEP_OP_VECTOR;
      i.memory_direction = 1'b1;
      i.angle_style_select = 1'b1;
      i.draw_enable = b[4];
      i.heading_code = b[7:5];
      i.pixel_count = 13'({9'h000, b[3:0]}) + 13'h0001;
      vec_issue = i;
   endfunction

   function automatic dep_pkg::dep_issue_t command_issue(
         input logic [15:0] c,
         input dep_pkg::dep_state_regs_t s);
      dep_pkg::dep_issue_t i;
      i = '0;
      unique case (c[15:13])
         3'b001:  i.op = dep_pkg::DEP_OP_LINE;
         3'b010:  i.op = dep_pkg::DEP_OP_FILL;
         3'b110:  i.op = dep_pkg::DEP_OP_COPY;
         3'b111:  i.op = dep_pkg::DEP_OP_PATTERN;
         default: i.op = dep_pkg::DEP_OP_NONE;
      endcase
      i.memory_direction = c[0];
      i.multi_pixel_select = c[1];
      i.skip_final_pixel = c[2];
      i.angle_style_select = c[3];
      i.draw_enable = c[4];
      i.heading_code = c[7:5];
      i.host_data_wait = c[8];
      i.wide_port = c[9];
      i.low_byte_first = c[`DEP_CMD_SWAP];
      i.pixel_count = 13'({1'b0, s.major_count[11:0]}) + 13'h0001;
      if (i.op == dep_pkg::DEP_OP_LINE && !c[3]) begin
         i.axial_step = s.axial_step[13:0];
         i.diagonal_step = s.diag_step[13:0];
         i.line_error_term = s.error_term[13:0];
      end
      if (i.op == dep_pkg::DEP_OP_COPY ||
          i.op == dep_pkg::DEP_OP_PATTERN) begin
         i.dest_x = s.diag_step[11:0];
      end
      command_issue = i;
   endfunction

   always_comb begin
      next_r = r;
      next_r.issue_valid = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      col_hit = 1'b0;
      entry = '0;
      head_e = r.queue[r.head];
      therm9 = 9'((9'h001 << r.count) - 9'h001);
      therm = therm9[7:0];
      // a full queue holds off command writes by waitrequest
      stall = avs_write && r.count == `DEP_QSLOTS &&
              (avs_address == `DEP_CMDSTAT || avs_address == `DEP_STROKE);
      acc = r.waitreq && (avs_read || avs_write) && !stall;
      if (!r.waitreq) begin
         next_r.waitreq = 1'b1;
      end else if (acc) begin
         next_r.waitreq = 1'b0;
         next_r.rdata = `DEP_RST32;
         unique case (avs_address)
            `DEP_AXSTEP: begin
               if (avs_write) begin
                  next_r.axial_step = m16(r.axial_step, avs_writedata[15:0], avs_byteenable[1:0]);
               end
               next_r.rdata = {16'h0000, r.axial_step};
            end
            `DEP_DIASTEP: begin
               if (avs_write) begin
                  next_r.diag_step = m16(r.diag_step, avs_writedata[15:0], avs_byteenable[1:0]);
               end
               next_r.rdata = {16'h0000, r.diag_step};
            end
            `DEP_ERRTERM: begin
               if (avs_write) begin
                  next_r.error_term = m16(r.error_term, avs_writedata[15:0], avs_byteenable[1:0]);
               end
               next_r.rdata = {16'h0000, r.error_term};
            end
            `DEP_MAJOR: begin
               if (avs_write) begin
                  next_r.major_count = m16(r.major_count, avs_writedata[15:0], avs_byteenable[1:0]);
               end
               next_r.rdata = {16'h0000, r.major_count};
            end
            `DEP_CMDSTAT: begin
               if (avs_write) begin
                  push = 1'b1;
                  entry = {1'b0, avs_writedata[15:0]};
               end
               next_r.rdata = {21'h000000, r.count == 4'h0, r.busy,
                               read_word_ready, therm};
            end
            `DEP_STROKE: begin
               if (avs_write) begin
                  push = 1'b1;
                  entry = {1'b1, avs_writedata[15:0]};
               end
            end
            `DEP_BGCOL: begin
               col_hit = 1'b1;
               if (avs_write) begin
                  next_r.bg_color = wr32(r.bg_color, avs_writedata, avs_byteenable,
                                         r.mode[`DEP_MODE_WIDE], r.mode[`DEP_MODE_HALF]);
               end
               next_r.rdata = rd32(r.bg_color, r.mode[`DEP_MODE_WIDE], r.mode[`DEP_MODE_HALF]);
            end
            `DEP_FGCOL: begin
               col_hit = 1'b1;
               if (avs_write) begin
                  next_r.fg_color = wr32(r.fg_color, avs_writedata, avs_byteenable,
                                         r.mode[`DEP_MODE_WIDE], r.mode[`DEP_MODE_HALF]);
               end
               next_r.rdata = rd32(r.fg_color, r.mode[`DEP_MODE_WIDE], r.mode[`DEP_MODE_HALF]);
            end
            `DEP_WMASK: begin
               col_hit = 1'b1;
               if (avs_write) begin
                  next_r.wmask = wr32(r.wmask, avs_writedata, avs_byteenable,
                                      r.mode[`DEP_MODE_WIDE], r.mode[`DEP_MODE_HALF]);
               end
               next_r.rdata = rd32(r.wmask, r.mode[`DEP_MODE_WIDE], r.mode[`DEP_MODE_HALF]);
            end
            `DEP_RMASK: begin
               col_hit = 1'b1;
               if (avs_write) begin
                  next_r.rmask = wr32(r.rmask, avs_writedata, avs_byteenable,
                                      r.mode[`DEP_MODE_WIDE], r.mode[`DEP_MODE_HALF]);
               end
               next_r.rdata = rd32(r.rmask, r.mode[`DEP_MODE_WIDE], r.mode[`DEP_MODE_HALF]);
            end
            `DEP_CMPCOL: begin
               col_hit = 1'b1;
               if (avs_write) begin
                  next_r.cmp_color = wr32(r.cmp_color, avs_writedata, avs_byteenable,
                                          r.mode[`DEP_MODE_WIDE], r.mode[`DEP_MODE_HALF]);
               end
               next_r.rdata = rd32(r.cmp_color, r.mode[`DEP_MODE_WIDE], r.mode[`DEP_MODE_HALF]);
            end
            `DEP_BGMIX: begin
               if (avs_write) begin
                  next_r.bg_mix = m16(r.bg_mix, avs_writedata[15:0], avs_byteenable[1:0]);
               end
               next_r.rdata = {16'h0000, r.bg_mix};
            end
            `DEP_FGMIX: begin
               if (avs_write) begin
                  next_r.fg_mix = m16(r.fg_mix, avs_writedata[15:0], avs_byteenable[1:0]);
               end
               next_r.rdata = {16'h0000, r.fg_mix};
            end
            `DEP_MODE: begin
               if (avs_write) begin
                  next_r.mode = 9'(m16({7'h00, r.mode}, avs_writedata[15:0], avs_byteenable[1:0]));
               end
               next_r.rdata = {23'h000000, r.mode};
            end
            default: next_r.rdata = `DEP_RST32;
         endcase
         if (col_hit && r.mode[`DEP_MODE_WIDE]) begin
            next_r.mode[`DEP_MODE_HALF] = ~r.mode[`DEP_MODE_HALF];
         end
      end
      if (push) begin
         next_r.queue[r.tail] = entry;
         next_r.tail = r.tail + 3'h1;
      end
      unique case (r.st)
         dep_pkg::DEP_IDLE: begin
            if (r.count != 4'h0) begin
               pop = 1'b1;
               next_r.head = r.head + 3'h1;
               if (head_e[16]) begin
                  next_r.issue = vec_issue(r.last_swap ? head_e[7:0] : head_e[15:8]);
                  next_r.pend_vec = r.last_swap ? head_e[15:8] : head_e[7:0];
                  next_r.issue_valid = 1'b1;
                  next_r.st = dep_pkg::DEP_VEC;
               end else begin
                  next_r.last_swap = head_e[`DEP_CMD_SWAP];
                  next_r.issue = command_issue(head_e[15:0], r);
                  // nop and reserved codes finish at once
                  if (next_r.issue.op != dep_pkg::DEP_OP_NONE) begin
                     next_r.issue_valid = 1'b1;
                     next_r.st = dep_pkg::DEP_RUN;
                  end
               end
            end
         end
         dep_pkg::DEP_RUN: begin
            if (engine_done) begin
               next_r.st = dep_pkg::DEP_IDLE;
            end
         end
         dep_pkg::DEP_VEC: begin
            if (engine_done) begin
               next_r.issue = vec_issue(r.pend_vec);
               next_r.issue_valid = 1'b1;
               next_r.st = dep_pkg::DEP_RUN;
            end
         end
         default: next_r.st = dep_pkg::DEP_IDLE;
      endcase
      next_r.count = 4'(r.count + {3'h0, push} - {3'h0, pop});
      // busy until queue and engine drain
      next_r.busy = next_r.count != 4'h0 || next_r.st != dep_pkg::DEP_IDLE;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= RST_ST;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign avs_waitrequest = r.waitreq;
   assign avs_readdata = r.rdata;
   assign issue = r.issue;
   assign issue_valid = r.issue_valid;
   assign pixel_cfg = '{background_color: r.bg_color,
                        foreground_color: r.fg_color,
                        plane_write_mask: r.wmask,
                        plane_read_mask: r.rmask,
                        compare_color: r.cmp_color,
                        bg_mix_fn: r.bg_mix[3:0],
                        bg_new_colour_source: r.bg_mix[6:5],
                        fg_mix_fn: r.fg_mix[3:0],
                        fg_new_colour_source: r.fg_mix[6:5],
                        compare_enable: r.mode[`DEP_MODE_CMP],
                        compare_polarity: r.mode[`DEP_MODE_POL]};

   AST_THERMO: assert property (@(posedge clk) disable iff (!resetn)
      ce && acc && avs_read && avs_address == `DEP_CMDSTAT
      |=> avs_readdata[7:0] == $past(therm))
      else $error("queue level not thermometer coded");
   AST_READY: assert property (@(posedge clk) disable iff (!resetn)
      ce && acc && avs_read && avs_address == `DEP_CMDSTAT
      |=> avs_readdata[8] == $past(read_word_ready))
      else $error("read data flag wrong");
   AST_IDLE: assert property (@(posedge clk) disable iff (!resetn)
      ce && r.count == 4'h0 && r.st == dep_pkg::DEP_IDLE && !push
      |=> !r.busy)
      else $error("busy with nothing queued");
   AST_BUSY: assert property (@(posedge clk) disable iff (!resetn)
      ce && push |=> r.busy && r.count != 4'h0 ##0 !avs_waitrequest)
      else $error("command write did not raise busy");
   AST_COUNT: assert property (@(posedge clk) disable iff (!resetn)
      ce && pop && !head_e[16] && head_e[15:13] == 3'b010
      |=> issue_valid && issue.pixel_count == 13'($past(r.major_count[11:0])) + 13'h0001)
      else $error("fill length not count plus one");
   AST_DESTX: assert property (@(posedge clk) disable iff (!resetn)
      issue_valid && issue.op != dep_pkg::DEP_OP_COPY &&
      issue.op != dep_pkg::DEP_OP_PATTERN |-> issue.dest_x == 12'h000)
      else $error("destination x used outside copies");
   AST_SKIP: assert property (@(posedge clk) disable iff (!resetn)
      ce && pop && !head_e[16] && head_e[15:13] == 3'b001
      |=> issue.skip_final_pixel == $past(head_e[2]))
      else $error("final pixel control lost");
   AST_RESERVED: assert property (@(posedge clk) disable iff (!resetn)
      ce && pop && !head_e[16] && head_e[15:13] inside {3'b011, 3'b100, 3'b101}
      |=> !issue_valid && r.st == dep_pkg::DEP_IDLE)
      else $error("reserved command was issued");
   AST_STROKE: assert property (@(posedge clk) disable iff (!resetn)
      ce && pop && head_e[16] && !r.last_swap
      |=> issue.heading_code == $past(head_e[15:13]) && r.pend_vec == $past(head_e[7:0]))
      else $error("short vectors out of order");
   AST_HALF: assert property (@(posedge clk) disable iff (!resetn)
      ce && acc && r.mode[`DEP_MODE_WIDE] &&
      avs_address inside {`DEP_BGCOL, `DEP_FGCOL, `DEP_WMASK, `DEP_RMASK, `DEP_CMPCOL}
      |=> r.mode[`DEP_MODE_HALF] != $past(r.mode[`DEP_MODE_HALF]))
      else $error("half select flag did not toggle");
endmodule
`default_nettype wire

/* verification/tb_draw_engine_param_regs.sv */
// self-checking bench for the drawing engine parameter bank
// assumes the dep_pkg package and dep_regs.svh header are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "dep_regs.svh"
module tb_draw_engine_param_regs;
   logic               clk;
   logic               resetn;
   logic               ce;
   logic               avs_read;
   logic               avs_write;
   logic               read_word_ready;
   logic               engine_done;
   logic [15:0]        avs_address;
   logic [31:0]        avs_writedata;
   logic [3:0]         avs_byteenable;
   logic [31:0]        avs_readdata;
   logic               avs_waitrequest;
   logic               issue_valid;
   dep_pkg::dep_issue_t     issue;
   dep_pkg::dep_pixel_cfg_t pixel_cfg;
   int                 fails;
   int                 n_tests;
   int                 k;
   int                 n_iss;
   int                 n_done;
   logic [31:0]        seed;
   logic [15:0]        c;
   logic [31:0]        rq[$];
   logic [31:0]        iq[$];
   localparam logic [15:0] AD [11] = '{`DEP_AXSTEP, `DEP_DIASTEP, `DEP_ERRTERM, `DEP_MAJOR, `DEP_BGMIX,
      `DEP_FGMIX, `DEP_BGCOL, `DEP_FGCOL, `DEP_WMASK, `DEP_RMASK, `DEP_CMPCOL};

   dep_param_regs u_dep_param_regs (.clk(clk), .resetn(resetn), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .read_word_ready(read_word_ready), .engine_done(engine_done), .issue(issue),
      .issue_valid(issue_valid), .pixel_cfg(pixel_cfg));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   task automatic summarize;
      if (fails == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // waits for the answer or a new issue, ends on the sampling edge
   task automatic await(input bit iss);
      int i;
      i = 0;
      do begin
         @(negedge clk);
         i++;
      end while (!(iss ? n_iss > n_done : avs_waitrequest === 1'b0) && i < 300);
      if (i >= 300) begin
         fails++;
         summarize();
      end
      @(posedge clk);
   endtask

   task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      await(1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      rq.push_back(e);
      acc(1'b0, a, 32'h0000_0000);
   endtask

   // done only after the issue pulse, as the engine would
   task automatic fin;
      await(1'b1);
      n_done++;
      engine_done <= 1'b1;
      @(posedge clk);
      engine_done <= 1'b0;
   endtask

   always @(posedge clk) if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk(avs_readdata, rq.pop_front());
   // issues are counted so a pulse seen before fin starts is not lost
   always @(posedge clk) begin
      if (issue_valid === 1'b1) begin
         n_iss++;
         chk({issue.op, issue.draw_enable, issue.heading_code}, iq.pop_front());
      end
   end

   initial begin
      {resetn, avs_read, avs_write, read_word_ready, engine_done} = 5'h00;
      ce = 1'b1;
      avs_byteenable = 4'hf;
      avs_address = 16'h0000;
      avs_writedata = 32'h0000_0000;
      seed = 32'he71d3aa3;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rd(`DEP_CMDSTAT, 32'h0000_0400);
      read_word_ready <= 1'b1;
      rd(`DEP_CMDSTAT, 32'h0000_0500);
      read_word_ready <= 1'b0;
      for (k = 0; k < 11; k++) begin
         seed = xs(seed);
         acc(1'b1, AD[k], seed);
         rd(AD[k], (k < 6) ? {16'h0000, seed[15:0]} : seed);
      end
      chk(pixel_cfg.compare_color, seed);
      rd(16'hc6e8, 32'h0000_0000);
      rd(`DEP_STROKE, 32'h0000_0000);
      // ce low: a pending read must not be taken
      ce <= 1'b0;
      avs_address <= `DEP_STROKE;
      avs_read <= 1'b1;
      repeat (3) @(posedge clk);
      chk(avs_waitrequest, 32'h0000_0001);
      ce <= 1'b1;
      rq.push_back(32'h0000_0000);
      await(1'b0);
      avs_read <= 1'b0;
      @(posedge clk);
      for (k = 0; k < 8; k++) begin
         seed = xs(seed);
         c = {k[2:0], seed[12], 2'b00, seed[9:0]};
         if (k inside {1, 2, 6, 7}) iq.push_back({k[2:0], c[4], c[7:5]});
         acc(1'b1, `DEP_CMDSTAT, {16'h0000, c});
         if (k inside {1, 2, 6, 7}) fin();
         else repeat (4) @(posedge clk);
      end
      // line with dx 5, dy 3, start X right of end X
      acc(1'b1, `DEP_AXSTEP, 32'h0000_0006);
      acc(1'b1, `DEP_DIASTEP, 32'h0000_3ffc);
      acc(1'b1, `DEP_ERRTERM, 32'h0000_0001);
      acc(1'b1, `DEP_MAJOR, 32'h0000_0004);
      iq.push_back({3'b001, 1'b1, 3'b100});
      acc(1'b1, `DEP_CMDSTAT, 32'h0000_2090);
      fin();
      chk(issue.axial_step, 32'h0000_0006);
      chk(issue.diagonal_step, 32'h0000_3ffc);
      chk(issue.line_error_term, 32'h0000_0001);
      chk(issue.pixel_count, 32'h0000_0005);
      iq.push_back({3'b110, 1'b1, 3'b000});
      acc(1'b1, `DEP_CMDSTAT, 32'h0000_c010);
      fin();
      chk(issue.dest_x, 32'h0000_0ffc);
      for (k = 0; k < 2; k++) begin
         acc(1'b1, `DEP_CMDSTAT, {16'h0000, 3'b000, k[0], 12'h000});
         c = 16'hb34a;
         iq.push_back(k ? {3'b011, c[4], c[7:5]} : {3'b011, c[12], c[15:13]});
         iq.push_back(k ? {3'b011, c[12], c[15:13]} : {3'b011, c[4], c[7:5]});
         acc(1'b1, `DEP_STROKE, {16'h0000, c});
         fin();
         fin();
      end
      for (k = 0; k < 9; k++) begin
         iq.push_back({3'b010, 1'b1, 3'b000});
         acc(1'b1, `DEP_CMDSTAT, 32'h0000_4010);
      end
      rd(`DEP_CMDSTAT, 32'h0000_02ff);
      repeat (9) fin();
      rd(`DEP_CMDSTAT, 32'h0000_0400);
      acc(1'b1, `DEP_MODE, 32'h0000_0001);
      acc(1'b1, `DEP_BGCOL, 32'h0000_aaaa);
      acc(1'b1, `DEP_BGCOL, 32'h0000_5555);
      chk(pixel_cfg.background_color, 32'h5555_aaaa);
      rd(`DEP_BGCOL, 32'h0000_aaaa);
      rd(`DEP_BGCOL, 32'h0000_5555);
      acc(1'b1, `DEP_MODE, 32'h0000_0180);
      acc(1'b1, `DEP_BGMIX, 32'h0000_0045);
      chk({pixel_cfg.compare_enable, pixel_cfg.compare_polarity}, 32'h0000_0003);
      chk({pixel_cfg.bg_new_colour_source, pixel_cfg.bg_mix_fn}, 32'h0000_0025);
      repeat (4) @(posedge clk);
      summarize();
   end
endmodule
`default_nettype wire
